// ---- ccp_pkg.sv ----
// package for the capture/compare/pwm channel: register offsets, field positions, modes
// assumes an 8-bit register port and one system clock
package ccp_pkg;
   // register offsets
   localparam logic [3:0] ADDR_CONTROL     = 4'h0;
   localparam logic [3:0] ADDR_MATCH_LOW   = 4'h1;
   localparam logic [3:0] ADDR_MATCH_HIGH  = 4'h2;
   localparam logic [3:0] ADDR_TB_SELECT_A = 4'h3;
   localparam logic [3:0] ADDR_STATUS      = 4'h4;
   localparam logic [3:0] ADDR_FLAG_CLEAR  = 4'h5;

   // channel_control fields
   localparam int CTL_EN_BIT   = 7;
   localparam int CTL_OUT_BIT  = 5;
   localparam int CTL_FMT_BIT  = 4;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] MATCH_RESET   = 8'h00;
   localparam logic [7:0] TBSEL_RESET   = 8'h00;

   // field position of this channel's time base select
   localparam int TBSEL_LSB = 0;

   // status bits
   localparam int ST_FLAG_BIT = 0;
   localparam int ST_PIN_BIT  = 1;

   // instruction clock divide: system clock / 4
   localparam logic [1:0] PHASE_LAST = 2'h3;

   typedef enum logic [3:0] {
      MODE_OFF        = 4'h0,
      MODE_TOGGLE_CLR = 4'h1,
      MODE_TOGGLE     = 4'h2,
      MODE_SET        = 4'h8,
      MODE_CLEAR      = 4'h9,
      MODE_PULSE      = 4'ha,
      MODE_PULSE_CLR  = 4'hb,
      MODE_PWM        = 4'hf
   } op_mode_t;

   // one 8-bit time base as seen by the channel
   typedef struct packed {
      logic [7:0] count;
      logic       step;       // count increments this cycle
      logic       period_hit; // count == period_limit on a step
      logic [1:0] pre_bits;   // prescaler low bits
      logic       pre_one;    // prescaler is 1:1
   } time_base_t;

   // compare-side 16-bit timer
   typedef struct packed {
      logic [15:0] count;
      logic        step;
   } compare_timer_t;
endpackage

// ---- ccp_match_edge.sv ----
// equality detector that fires once per timer step reaching equality
// assumes the step strobe and values are on the same clock
`timescale 1ns/1ps
module ccp_match_edge #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // compare operands
   input  wire logic [WIDTH-1:0] a,
   input  wire logic [WIDTH-1:0] b,
   input  wire logic             step,
   // results
   output logic                  equal,
   output logic                  hit
);
   typedef struct packed {
      logic prev;
   } edge_state_t;

   edge_state_t s_reg;
   edge_state_t s_next;

   initial begin
      if (WIDTH < 1) $error("width must be positive");
   end

   assign equal = (a == b);
   // fires once on equality freshly reached; a step re-arms the detector
   assign hit = equal && !s_reg.prev;

   always_comb begin
      s_next = s_reg;
      s_next.prev = equal && !step;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// ---- ccp_channel.sv ----
// capture/compare/pwm channel: compare against 16-bit timer and 10-bit pwm
// assumes timers live outside; their counts and step strobes arrive on clk
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps

//Function
// - timer held in sleep with instruction clock
// - capture keeps working with external timer clock
// - compare 16-bit pair against timer continuously
// - match toggles, sets or clears output
// - match sets flag and converter trigger
// - zero control write clears output latch
// - output also routed to peripherals
// - flag with selected source gives conversion trigger
// - timer clear skipped if match removed
// - compare in sleep needs running timer; wakes
// - pwm pulse train up to ten bits
// - channel selects one of three time bases
// - period is (limit+1) times four times prescale
// - period hit sets pin unless duty is zero, loads duty buffer
// - postscaler does not affect pwm frequency
// - duty aligned by format, buffered at period
// - pin cleared when time base equals duty
// - time base is count plus two low bits
// - operation field encodings as listed
// - format one left, zero right aligned
module ccp_channel #(
   parameter int NUM_BASES = 3
) (
   // clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 rstn,
   // register port
   input  wire logic [3:0]                           addr,
   input  wire logic [7:0]                           wdata,
   input  wire logic                                 wr,
   input  wire logic                                 rd,
   output logic      [7:0]                           rdata,
   // timers
   input  wire ccp_pkg::compare_timer_t              ctimer,
   input  wire ccp_pkg::time_base_t [NUM_BASES-1:0]  bases,
   input  wire logic                                 sleeping,
   input  wire logic                                 ctimer_external,
   // capture source from the pin
   input  wire logic                                 pin_in,
   // converter trigger selection and wake enable
   input  wire logic                                 trigger_selected,
   input  wire logic                                 channel_event_enable,
   // outputs
   output logic                                      channel_out,
   output logic                                      pin_oe_n,
   output logic                                      channel_event_flag,
   output logic                                      convert_trigger,
   output logic                                      ctimer_clear,
   output logic                                      ctimer_hold,
   output logic                                      wake_request
);
   typedef struct packed {
      logic [7:0]  control;
      logic [7:0]  match_low;
      logic [7:0]  match_high;
      logic [7:0]  tb_select;
      logic        out_latch;
      logic        flag;
      logic        trig;
      logic        clr_pending;
      logic        clr;
      logic [9:0]  duty_buf;
      logic [1:0]  phase;
      logic [7:0]  rdata;
      logic [2:0]  pin_sync;
      logic        pin_level;
      logic        capt_hit;
   } chan_state_t;

   chan_state_t s_reg;
   chan_state_t s_next;

   initial begin
      if (NUM_BASES != 3) $error("three time bases are supported");
   end

   logic [15:0]          match_pair;
   logic                 cmp_equal;
   logic                 cmp_hit;
   ccp_pkg::op_mode_t    mode;
   logic                 enabled;
   logic                 is_compare;
   logic                 is_capture;
   ccp_pkg::time_base_t  tb;
   logic [1:0]           tb_idx;
   logic [9:0]           time_base10;
   logic [9:0]           duty_raw;
   logic                 capt_edge;

   assign match_pair = {s_reg.match_high, s_reg.match_low};
   assign mode       = ccp_pkg::op_mode_t'(s_reg.control[3:0]);
   assign enabled    = s_reg.control[ccp_pkg::CTL_EN_BIT];
   assign is_compare = (s_reg.control[3:0] == 4'h1) || (s_reg.control[3:0] == 4'h2)
                       || (s_reg.control[3:2] == 2'h2);
   assign is_capture = (s_reg.control[3:2] == 2'h1) || (s_reg.control[3:0] == 4'h3);

   // compare against 16-bit timer, once per step
   ccp_match_edge #(
      .WIDTH (16)
   ) u_match (
      .clk   (clk),
      .rstn  (rstn),
      .a     (match_pair),
      .b     (ctimer.count),
      .step  (ctimer.step),
      .equal (cmp_equal),
      .hit   (cmp_hit)
   );

   // time base selection per channel
   always_comb begin
      tb_idx = s_reg.tb_select[ccp_pkg::TBSEL_LSB +: 2];
      if (tb_idx == 2'h2) begin
         tb = bases[2];
      end else if (tb_idx == 2'h1) begin
         tb = bases[1];
      end else begin
         tb = bases[0];
      end
   end

   // 10-bit time base: count plus phase or prescaler bits
   assign time_base10 = {tb.count, (tb.pre_one ? s_reg.phase : tb.pre_bits)};

   // duty alignment by format bit
   assign duty_raw = s_reg.control[ccp_pkg::CTL_FMT_BIT] ? {s_reg.match_high, s_reg.match_low[7:6]}
                                                         : {s_reg.match_high[1:0], s_reg.match_low};

   // capture on synchronised edges; sleep stops it unless the timer clock is external
   always_comb begin
      capt_edge = 1'b0;
      if (s_reg.control[3:0] == 4'h4) begin
         capt_edge = s_reg.pin_level && !s_reg.pin_sync[2] && (s_reg.pin_sync[1] == s_reg.pin_sync[2]);
      end else if (is_capture) begin
         capt_edge = !s_reg.pin_level && s_reg.pin_sync[2] && (s_reg.pin_sync[1] == s_reg.pin_sync[2]);
      end
   end

   always_comb begin
      s_next = s_reg;
      s_next.trig = 1'b0;
      s_next.clr = 1'b0;
      s_next.capt_hit = 1'b0;
      s_next.rdata = 8'h00;
      s_next.pin_sync = {s_reg.pin_sync[1:0], pin_in};
      if (s_reg.pin_sync[1] == s_reg.pin_sync[2]) begin
         s_next.pin_level = s_reg.pin_sync[2];
      end
      // system clock phase for the 1:1 prescaler case
      s_next.phase = s_reg.phase + 2'h1;
      if (tb.step && tb.pre_one) begin
         s_next.phase = 2'h0;
      end

      if (enabled && is_capture && capt_edge && (!sleeping || ctimer_external)) begin
         s_next.match_low = ctimer.count[7:0];
         s_next.match_high = ctimer.count[15:8];
         s_next.flag = 1'b1;
         s_next.capt_hit = 1'b1;
      end

      // compare match actions
      if (enabled && is_compare && cmp_hit) begin
         case (mode)
            ccp_pkg::MODE_TOGGLE_CLR,
            ccp_pkg::MODE_TOGGLE: begin
               s_next.out_latch = !s_reg.out_latch;
            end
            ccp_pkg::MODE_SET: begin
               s_next.out_latch = 1'b1;
            end
            ccp_pkg::MODE_CLEAR: begin
               s_next.out_latch = 1'b0;
            end
            default: begin
               s_next.out_latch = s_reg.out_latch;
            end
         endcase
         s_next.flag = 1'b1;
         s_next.trig = trigger_selected;
         s_next.clr_pending = (mode == ccp_pkg::MODE_TOGGLE_CLR) || (mode == ccp_pkg::MODE_PULSE_CLR);
      end
      // timer clear one edge after trigger, only if still matching
      if (s_reg.clr_pending) begin
         s_next.clr_pending = 1'b0;
         s_next.clr = cmp_equal;
      end

      // pwm: period hit sets pin, buffers duty
      if (enabled && mode == ccp_pkg::MODE_PWM) begin
         if (tb.period_hit) begin
            s_next.duty_buf = duty_raw;
            s_next.out_latch = (duty_raw != 10'h000);
         end else if ((time_base10 + 10'h001) == s_reg.duty_buf) begin
            s_next.out_latch = 1'b0;
         end
      end

      // register port; write strobe loses to hardware flag set
      if (wr) begin
         if (addr == ccp_pkg::ADDR_CONTROL) begin
            s_next.control = wdata & 8'hbf;
            if (wdata == 8'h00) begin
               s_next.out_latch = 1'b0;
               s_next.clr_pending = 1'b0;
            end
         end else if (addr == ccp_pkg::ADDR_MATCH_LOW) begin
            s_next.match_low = wdata;
         end else if (addr == ccp_pkg::ADDR_MATCH_HIGH) begin
            s_next.match_high = wdata;
         end else if (addr == ccp_pkg::ADDR_TB_SELECT_A) begin
            s_next.tb_select = wdata;
         end else if (addr == ccp_pkg::ADDR_FLAG_CLEAR) begin
            if (wdata[ccp_pkg::ST_FLAG_BIT] && !(s_next.trig || s_next.capt_hit
                || (enabled && is_compare && cmp_hit))) begin
               s_next.flag = 1'b0;
            end
         end
      end
      if (rd) begin
         if (addr == ccp_pkg::ADDR_CONTROL) begin
            s_next.rdata = {s_reg.control[7:6], s_reg.out_latch, s_reg.control[4:0]};
         end else if (addr == ccp_pkg::ADDR_MATCH_LOW) begin
            s_next.rdata = s_reg.match_low;
         end else if (addr == ccp_pkg::ADDR_MATCH_HIGH) begin
            s_next.rdata = s_reg.match_high;
         end else if (addr == ccp_pkg::ADDR_TB_SELECT_A) begin
            s_next.rdata = s_reg.tb_select;
         end else if (addr == ccp_pkg::ADDR_STATUS) begin
            s_next.rdata = {6'h00, s_reg.pin_level, s_reg.flag};
         end else begin
            s_next.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata              = s_reg.rdata;
   assign channel_out        = s_reg.out_latch;
   assign pin_oe_n           = !(enabled && (is_compare || mode == ccp_pkg::MODE_PWM));
   assign channel_event_flag = s_reg.flag;
   assign convert_trigger    = s_reg.trig;
   assign ctimer_clear       = s_reg.clr;
   // hold the count in sleep when clocked from instruction clock
   assign ctimer_hold        = sleeping && !ctimer_external;
   assign wake_request       = s_reg.flag && channel_event_enable;
endmodule

// ---- ccp_timers_model.sv ----
// timer model: 16-bit compare timer and three 8-bit time bases
// assumes every step comes at system clock / 4
`timescale 1ns/1ps
module ccp_timers_model #(
   parameter logic [23:0] LIMITS = 24'h050307
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rstn,
   // control
   input  wire logic                  restart,
   input  wire logic                  clear,
   input  wire logic                  hold,
   // timers
   output ccp_pkg::compare_timer_t    ctimer,
   output ccp_pkg::time_base_t [2:0]  bases
);
   logic [1:0]  phase;
   logic [15:0] ccount;
   assign ctimer.count = ccount;
   assign ctimer.step  = phase == 2'h3 && !hold;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase  <= 2'h0;
         ccount <= 16'h0000;
      end else begin
         phase <= phase + 2'h1;
         if (restart || clear) ccount <= 16'h0000;
         else if (ctimer.step) ccount <= ccount + 16'h0001;
      end
   end
   for (genvar i = 0; i < 3; i++) begin : g_base
      logic [7:0] cnt;
      assign bases[i].count      = cnt;
      assign bases[i].step       = phase == 2'h3;
      assign bases[i].period_hit = phase == 2'h3 && cnt == LIMITS[8*i +: 8];
      assign bases[i].pre_bits   = 2'h0;
      assign bases[i].pre_one    = 1'b1;
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) cnt <= 8'h00;
         else if (bases[i].step) cnt <= bases[i].period_hit ? 8'h00 : cnt + 8'h01;
      end
   end
endmodule

// ---- ccp_channel_sva.sv ----
// port assertions for the channel
// assumes one clock domain, bound into ccp_channel
`timescale 1ns/1ps
module ccp_channel_sva (
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   // levels
   input wire logic       sleeping,
   input wire logic       ctimer_external,
   input wire logic       trigger_selected,
   input wire logic       channel_event_enable,
   // outputs
   input wire logic       channel_out,
   input wire logic       channel_event_flag,
   input wire logic       convert_trigger,
   input wire logic       ctimer_clear,
   input wire logic       ctimer_hold,
   input wire logic       wake_request
);
   logic clr_wr;
   assign clr_wr = wr && (addr == ccp_pkg::ADDR_CONTROL || addr == ccp_pkg::ADDR_FLAG_CLEAR && wdata[0]);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_zero_ctl;
      wr && addr == ccp_pkg::ADDR_CONTROL && wdata == 8'h00;
   endsequence
   AST_HOLD: assert property (ctimer_hold == (sleeping && !ctimer_external))
      else $error("hold level wrong");
   AST_WAKE: assert property (wake_request == (channel_event_flag && channel_event_enable))
      else $error("wake level wrong");
   AST_TRIG_SEL: assert property (convert_trigger |-> $past(trigger_selected))
      else $error("trigger without selection");
   AST_TRIG_FLAG: assert property (convert_trigger |-> channel_event_flag)
      else $error("trigger without flag");
   AST_TRIG_ONE: assert property (convert_trigger |=> !convert_trigger)
      else $error("trigger longer than one cycle");
   AST_CLR_ONE: assert property (ctimer_clear |=> !ctimer_clear)
      else $error("timer clear longer than one cycle");
   AST_CLR_FLAG: assert property (ctimer_clear |-> $past(channel_event_flag))
      else $error("timer clear without match");
   AST_OUT_ZERO: assert property (s_zero_ctl |=> !channel_out)
      else $error("output latch not cleared");
   AST_FLAG_FALL: assert property ($fell(channel_event_flag) |-> $past(clr_wr))
      else $error("flag dropped by itself");
endmodule
bind ccp_channel ccp_channel_sva i_sva (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
   .sleeping(sleeping), .ctimer_external(ctimer_external), .trigger_selected(trigger_selected),
   .channel_event_enable(channel_event_enable), .channel_out(channel_out),
   .channel_event_flag(channel_event_flag), .convert_trigger(convert_trigger),
   .ctimer_clear(ctimer_clear), .ctimer_hold(ctimer_hold), .wake_request(wake_request));

// ---- ccp_channel_test.sv ----
// bench for ccp_channel: registers, compare actions, sleep hold, pwm timing
// assumes ccp_timers_model drives the timers; the pin has a pull-up
`timescale 1ns/1ps
module ccp_channel_test;
   localparam logic [23:0] LIMITS = 24'h050307;
   logic                      clk = 1'b0;
   logic                      rstn = 1'b0;
   logic [3:0]                addr = 4'h0;
   logic [7:0]                wdata = 8'h00;
   logic                      wr = 1'b0;
   logic                      rd = 1'b0;
   logic                      restart = 1'b0;
   logic                      sleeping = 1'b0;
   logic                      ext = 1'b0;
   logic                      sel = 1'b0;
   logic                      pin_drv = 1'b1;
   logic                      ien = 1'b1;
   logic [7:0]                rdata;
   ccp_pkg::compare_timer_t   ctimer;
   ccp_pkg::time_base_t [2:0] bases;
   logic                      out, oe_n, flag, trig, clr, hold, wake, pin, prev;
   int                        err_total = 0;
   int                        n_checks = 0;
   int                        trig_n = 0;
   int                        clr_n = 0;
   int                        per, hi_n, rise_n;
   logic [9:0]                duty;
   logic [15:0]               c0;
   logic [7:0]                ctab [6] = '{8'hc8, 8'h09, 8'hc2, 8'h82, 8'hc1, 8'h4a};
   logic [23:0]               ptab [4] = '{24'h000010, 24'h010240, 24'h100004, 24'h200000};
   always #10 clk = ~clk;
   assign pin = oe_n ? pin_drv : out;
   always @(posedge clk) begin
      trig_n <= trig_n + int'(trig === 1'b1);
      clr_n  <= clr_n + int'(clr === 1'b1);
   end
   ccp_timers_model #(.LIMITS(LIMITS)) i_tmr (.clk(clk), .rstn(rstn), .restart(restart), .clear(clr),
      .hold(hold), .ctimer(ctimer), .bases(bases));
   ccp_channel i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .ctimer(ctimer), .bases(bases), .sleeping(sleeping), .ctimer_external(ext), .pin_in(pin),
      .trigger_selected(sel), .channel_event_enable(ien), .channel_out(out), .pin_oe_n(oe_n),
      .channel_event_flag(flag), .convert_trigger(trig), .ctimer_clear(clr), .ctimer_hold(hold),
      .wake_request(wake));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(16'(rdata), 16'(exp));
      @(posedge clk);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 4; a++) rchk(4'(a), 8'h00);
      rchk(ccp_pkg::ADDR_STATUS, 8'h02);
      rchk(4'hf, 8'h00);
      $display("test reset done");
      wreg(ccp_pkg::ADDR_MATCH_LOW, 8'h10);
      wreg(ccp_pkg::ADDR_MATCH_HIGH, 8'h00);
      foreach (ctab[i]) begin
         restart <= 1'b1;
         sel <= ctab[i][7];
         @(posedge clk);
         restart <= 1'b0;
         wreg(ccp_pkg::ADDR_CONTROL, {4'h8, ctab[i][3:0]});
         for (int k = 0; k < 400 && flag !== 1'b1; k++) @(posedge clk);
         repeat (4) @(posedge clk);
         chk(16'(out), 16'(ctab[i][6]));
         chk(16'(oe_n), 16'h0000);
         rchk(ccp_pkg::ADDR_STATUS, {6'h00, ctab[i][6], 1'b1});
         rchk(ccp_pkg::ADDR_CONTROL, {2'h2, ctab[i][6], 1'b0, ctab[i][3:0]});
         chk(16'(wake), 16'h0001);
         ien <= 1'b0;
         @(posedge clk);
         chk(16'(wake), 16'h0000);
         ien <= 1'b1;
         wreg(ccp_pkg::ADDR_FLAG_CLEAR, 8'h01);
         chk(16'(flag), 16'h0000);
      end
      chk(16'(trig_n), 16'h0004);
      chk(16'(clr_n > 0), 16'h0001);
      wreg(ccp_pkg::ADDR_CONTROL, 8'h00);
      chk(16'(out), 16'h0000);
      $display("test compare done");
      sleeping <= 1'b1;
      @(posedge clk);
      c0 = ctimer.count;
      repeat (20) @(posedge clk);
      chk(ctimer.count, c0);
      ext <= 1'b1;
      repeat (20) @(posedge clk);
      chk(16'(ctimer.count != c0), 16'h0001);
      wreg(ccp_pkg::ADDR_CONTROL, 8'h84);
      pin_drv <= 1'b0;
      repeat (8) @(posedge clk);
      rchk(ccp_pkg::ADDR_STATUS, 8'h01);
      wreg(ccp_pkg::ADDR_FLAG_CLEAR, 8'h01);
      wreg(ccp_pkg::ADDR_CONTROL, 8'h00);
      pin_drv <= 1'b1;
      sleeping <= 1'b0;
      ext <= 1'b0;
      $display("test sleep and capture done");
      foreach (ptab[i]) begin
         wreg(ccp_pkg::ADDR_TB_SELECT_A, ptab[i][23:16]);
         wreg(ccp_pkg::ADDR_MATCH_LOW, ptab[i][7:0]);
         wreg(ccp_pkg::ADDR_MATCH_HIGH, ptab[i][15:8]);
         wreg(ccp_pkg::ADDR_CONTROL, {3'h4, ptab[i][16], 4'hf});
         duty = ptab[i][16] ? {ptab[i][15:8], ptab[i][7:6]} : {ptab[i][9:8], ptab[i][7:0]};
         per = (int'(LIMITS[8*ptab[i][17:16] +: 8]) + 1) * 4;
         repeat (3 * per) @(posedge clk);
         hi_n = 0;
         rise_n = 0;
         prev = out;
         repeat (4 * per) begin
            @(posedge clk);
            #1 hi_n += int'(out);
            rise_n += int'(out && !prev);
            prev = out;
         end
         chk(16'(hi_n), 16'(4 * duty));
         chk(16'(rise_n), duty == 10'h000 ? 16'h0000 : 16'h0004);
      end
      $display("test pwm done");
      end_sim();
   end
endmodule
